// >>> shared/scrb_pkg.sv
package scrb_pkg;

	localparam logic [14:0] SCRB_ADDR_CFG_A = 15'h0000;
	localparam logic [14:0] SCRB_ADDR_CFG_B = 15'h0001;
	localparam logic [14:0] SCRB_ADDR_PWR = 15'h0002;
	localparam logic [14:0] SCRB_ADDR_CLASS = 15'h0003;
	localparam logic [14:0] SCRB_ADDR_CHAN = 15'h0008;

	localparam int unsigned SCRB_A_SOFT_MIR_BIT = 7;
	localparam int unsigned SCRB_A_LSB_MIR_BIT = 6;
	localparam int unsigned SCRB_A_ASC_MIR_BIT = 5;
	localparam int unsigned SCRB_A_ASC_BIT = 2;
	localparam int unsigned SCRB_A_LSB_BIT = 1;
	localparam int unsigned SCRB_A_SOFT_BIT = 0;
	localparam int unsigned SCRB_B_DP_RST_BIT = 1;

	localparam logic SCRB_LSB_RST = 1'b0;
	localparam logic SCRB_ASC_RST = 1'b0;
	localparam logic [1:0] SCRB_PWR_RST = 2'h0;
	localparam logic [1:0] SCRB_CHAN_RST = 2'h3;

	localparam logic [1:0] SCRB_PWR_NORMAL = 2'h0;
	localparam logic [1:0] SCRB_PWR_STANDBY = 2'h2;
	localparam logic [1:0] SCRB_PWR_DOWN = 2'h3;

	// arbitrary value, not a real part code
	localparam logic [7:0] SCRB_CLASS_CODE = 8'h5a;

	localparam logic [3:0] SCRB_INST_LAST = 4'hf;
	localparam logic [3:0] SCRB_BYTE_LAST = 4'h7;

	typedef enum logic [1:0] {SCRB_INST, SCRB_DATA, SCRB_HOLD} scrb_state_t;

	function automatic logic [15:0] scrb_shift(input logic [15:0] cur, input logic din, input logic lsb,
		input logic wide);
		if (!lsb)
			scrb_shift = {cur[14:0], din};
		else if (wide)
			scrb_shift = {din, cur[15:1]};
		else
			scrb_shift = {8'h00, din, cur[7:1]};
	endfunction

	function automatic logic [14:0] scrb_step(input logic [14:0] addr, input logic asc);
		scrb_step = asc ? 15'(addr + 15'h0001) : 15'(addr - 15'h0001);
	endfunction

endpackage

// >>> shared/scrb_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
interface scrb_bus_if;
	logic wr;
	logic [14:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic lsb_first;
	logic addr_asc;
	logic soft_rst;
	modport eng(output wr, addr, wdata, input rdata, lsb_first, addr_asc, soft_rst);
	modport bank(input wr, addr, wdata, output rdata, lsb_first, addr_asc, soft_rst);
endinterface
`default_nettype wire

// >>> logic/scrb_regs.sv
`timescale 1ns/10ps
`default_nettype none
module scrb_regs
	import scrb_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ce,
	scrb_bus_if.bank bus,
	output logic [1:0] pwr_a,
	output logic [1:0] pwr_b,
	output logic dp_rst
);
	logic lsb_r, asc_r, soft_r, dp_rst_r;
	logic [1:0] pwr_a_r, pwr_b_r, chan_r;
	logic wr_a, wr_b, wr_p, wr_c;

	assign wr_a = bus.wr && bus.addr == SCRB_ADDR_CFG_A;
	assign wr_b = bus.wr && bus.addr == SCRB_ADDR_CFG_B;
	assign wr_p = bus.wr && bus.addr == SCRB_ADDR_PWR;
	assign wr_c = bus.wr && bus.addr == SCRB_ADDR_CHAN;
	assign bus.lsb_first = lsb_r;
	assign bus.addr_asc = asc_r;
	assign bus.soft_rst = soft_r;
	assign pwr_a = pwr_a_r;
	assign pwr_b = pwr_b_r;
	assign dp_rst = dp_rst_r;

	// one-cycle pulse; never stored, so both positions read back zero
	always_ff @(posedge core_clk) begin
		if (!nrst)
			soft_r <= 1'b0;
		else if (ce)
			soft_r <= wr_a && (bus.wdata[SCRB_A_SOFT_MIR_BIT] || bus.wdata[SCRB_A_SOFT_BIT]);
	end

	always_ff @(posedge core_clk) begin
		if (!nrst)
			dp_rst_r <= 1'b0;
		else if (ce)
			dp_rst_r <= wr_b && bus.wdata[SCRB_B_DP_RST_BIT];
	end

	// a conflicting write of primary and mirror resolves to set
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			lsb_r <= SCRB_LSB_RST;
			asc_r <= SCRB_ASC_RST;
		end else if (ce) begin
			if (soft_r) begin
				lsb_r <= SCRB_LSB_RST;
				asc_r <= SCRB_ASC_RST;
			end else if (wr_a) begin
				lsb_r <= bus.wdata[SCRB_A_LSB_MIR_BIT] | bus.wdata[SCRB_A_LSB_BIT];
				asc_r <= bus.wdata[SCRB_A_ASC_MIR_BIT] | bus.wdata[SCRB_A_ASC_BIT];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pwr_a_r <= SCRB_PWR_RST;
			pwr_b_r <= SCRB_PWR_RST;
			chan_r <= SCRB_CHAN_RST;
		end else if (ce) begin
			if (soft_r) begin
				pwr_a_r <= SCRB_PWR_RST;
				pwr_b_r <= SCRB_PWR_RST;
				chan_r <= SCRB_CHAN_RST;
			end else begin
				if (wr_p && chan_r[0])
					pwr_a_r <= bus.wdata[1:0];
				if (wr_p && chan_r[1])
					pwr_b_r <= bus.wdata[1:0];
				if (wr_c)
					chan_r <= bus.wdata[1:0];
			end
		end
	end

	always_comb begin
		bus.rdata = 8'h00;
		case (bus.addr)
			SCRB_ADDR_CFG_A: bus.rdata = {1'b0, lsb_r, asc_r, 2'b00, asc_r, lsb_r, 1'b0};
			SCRB_ADDR_PWR: bus.rdata = {6'h00, (chan_r[0] || !chan_r[1]) ? pwr_a_r : pwr_b_r};
			SCRB_ADDR_CLASS: bus.rdata = SCRB_CLASS_CODE;
			SCRB_ADDR_CHAN: bus.rdata = {6'h00, chan_r};
			default: bus.rdata = 8'h00;
		endcase
	end

	a_soft_trigger: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
		(wr_a && (bus.wdata[SCRB_A_SOFT_MIR_BIT] || bus.wdata[SCRB_A_SOFT_BIT])) |=> soft_r ##1 !soft_r)
		else $error("soft reset did not pulse for one cycle");
	a_soft_defaults: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
		soft_r |=> (lsb_r == SCRB_LSB_RST && asc_r == SCRB_ASC_RST && chan_r == SCRB_CHAN_RST
		&& pwr_a_r == SCRB_PWR_RST && pwr_b_r == SCRB_PWR_RST))
		else $error("defaults not reloaded after soft reset");
	a_dp_pulse: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
		(wr_b && bus.wdata[SCRB_B_DP_RST_BIT]) |=> dp_rst_r ##1 !dp_rst_r)
		else $error("datapath reset did not self clear");
	a_mirror_read: assert property (@(posedge core_clk) disable iff (!nrst)
		(bus.addr == SCRB_ADDR_CFG_A) |-> (bus.rdata[6] == bus.rdata[1] && bus.rdata[5] == bus.rdata[2]
		&& !bus.rdata[7] && !bus.rdata[0]))
		else $error("mirror bits disagree on read");
	a_mirror_write: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
		(wr_a && !soft_r) |=> lsb_r == ($past(bus.wdata[6]) | $past(bus.wdata[1])))
		else $error("bit order not stored from either position");
	a_chan_write: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
		(wr_p && chan_r == 2'h2 && !soft_r) |=> (pwr_a_r == $past(pwr_a_r) && pwr_b_r == $past(bus.wdata[1:0])))
		else $error("channel select not honoured on write");
	a_read_both: assert property (@(posedge core_clk) disable iff (!nrst)
		(bus.addr == SCRB_ADDR_PWR && chan_r == 2'h3) |-> bus.rdata[1:0] == pwr_a_r)
		else $error("both channels selected did not return channel a");
endmodule
`default_nettype wire

// >>> logic/scrb_top.sv
`timescale 1ns/10ps
`default_nettype none
module scrb_top
	import scrb_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic sclk,
	input wire logic csb_n,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe,
	output logic dp_rst,
	output logic [1:0] dp_clk_en,
	output logic [1:0] dp_hold_rst,
	output logic [1:0] link_en
);
	scrb_bus_if bus();

	logic sclk_s1, sclk_s2, sclk_s3, csb_s1, csb_s2, din_s1, din_s2;
	logic rise, fall;
	scrb_state_t state_r;
	logic [3:0] cnt_r;
	logic [15:0] shift_r, shift_nxt;
	logic rw_r, wr_r, step_r, load_r;
	logic [14:0] addr_r;
	logic [7:0] wdata_r, tx_r;
	logic sdio_o_r, sdio_oe_r, dp_rst_r, dp_pulse;
	logic [1:0] pwr_v [2];
	logic [1:0] clk_en_r, hold_r, link_r;

	scrb_regs u_regs (
		.core_clk(core_clk),
		.nrst(nrst),
		.ce(ce),
		.bus(bus.bank),
		.pwr_a(pwr_v[0]),
		.pwr_b(pwr_v[1]),
		.dp_rst(dp_pulse)
	);

	assign bus.wr = wr_r;
	assign bus.addr = addr_r;
	assign bus.wdata = wdata_r;
	assign sdio_o = sdio_o_r;
	assign sdio_oe = sdio_oe_r;
	assign dp_rst = dp_rst_r;
	assign dp_clk_en = clk_en_r;
	assign dp_hold_rst = hold_r;
	assign link_en = link_r;

	// pins are asynchronous to core_clk; edges judged only on settled copies
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			csb_s1 <= 1'b1;
			csb_s2 <= 1'b1;
			din_s1 <= 1'b0;
			din_s2 <= 1'b0;
		end else if (ce) begin
			sclk_s1 <= sclk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			csb_s1 <= csb_n;
			csb_s2 <= csb_s1;
			din_s1 <= sdio_i;
			din_s2 <= din_s1;
		end
	end

	assign rise = sclk_s2 && !sclk_s3 && !csb_s2;
	assign fall = !sclk_s2 && sclk_s3 && !csb_s2;
	assign shift_nxt = scrb_shift(shift_r, din_s2, bus.lsb_first, state_r == SCRB_INST);

	// instruction: r/w flag then 15-bit address; ends up in bit 15 in both orders
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_r <= SCRB_INST;
			cnt_r <= 4'h0;
			shift_r <= 16'h0000;
			rw_r <= 1'b0;
			wr_r <= 1'b0;
			wdata_r <= 8'h00;
			step_r <= 1'b0;
		end else if (ce) begin
			wr_r <= 1'b0;
			step_r <= 1'b0;
			if (bus.soft_rst) begin
				// rest of a frame carrying the reset is ignored
				state_r <= SCRB_HOLD;
				cnt_r <= 4'h0;
			end else if (csb_s2) begin
				state_r <= SCRB_INST;
				cnt_r <= 4'h0;
			end else begin
				unique case (state_r)
					SCRB_INST: begin
						if (rise) begin
							shift_r <= shift_nxt;
							cnt_r <= 4'(cnt_r + 4'h1);
							if (cnt_r == SCRB_INST_LAST) begin
								state_r <= SCRB_DATA;
								cnt_r <= 4'h0;
								rw_r <= shift_nxt[15];
							end
						end
					end
					SCRB_DATA: begin
						if (rise) begin
							shift_r <= shift_nxt;
							cnt_r <= 4'(cnt_r + 4'h1);
							if (cnt_r == SCRB_BYTE_LAST) begin
								cnt_r <= 4'h0;
								wr_r <= !rw_r;
								wdata_r <= shift_nxt[7:0];
								step_r <= 1'b1;
							end
						end
					end
					SCRB_HOLD: begin
					end
				endcase
			end
		end
	end

	// address moves one cycle after the byte so a write sees its own address
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			addr_r <= 15'h0000;
			load_r <= 1'b0;
		end else if (ce) begin
			load_r <= 1'b0;
			if (state_r == SCRB_INST && rise && cnt_r == SCRB_INST_LAST && !csb_s2 && !bus.soft_rst) begin
				addr_r <= shift_nxt[14:0];
				load_r <= shift_nxt[15];
			end else if (step_r) begin
				addr_r <= scrb_step(addr_r, bus.addr_asc);
				load_r <= rw_r;
			end
		end
	end

	// read data leaves on falling sclk so it is stable at the next rising edge
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			tx_r <= 8'h00;
			sdio_o_r <= 1'b0;
			sdio_oe_r <= 1'b0;
		end else if (ce) begin
			sdio_oe_r <= state_r == SCRB_DATA && rw_r && !csb_s2;
			if (load_r) begin
				tx_r <= bus.rdata;
			end else if (fall && state_r == SCRB_DATA && rw_r) begin
				sdio_o_r <= bus.lsb_first ? tx_r[0] : tx_r[7];
				tx_r <= bus.lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
			end
		end
	end

	// chip soft reset also restarts the datapath
	always_ff @(posedge core_clk) begin
		if (!nrst)
			dp_rst_r <= 1'b1;
		else if (ce)
			dp_rst_r <= dp_pulse || bus.soft_rst;
	end

	// undefined code 01 behaves as normal: only bit 1 gates clocks
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			clk_en_r <= 2'b11;
			hold_r <= 2'b00;
			link_r <= 2'b11;
		end else if (ce) begin
			for (int i = 0; i < 2; i++) begin
				clk_en_r[i] <= !pwr_v[i][1];
				hold_r[i] <= pwr_v[i] == SCRB_PWR_DOWN;
				link_r[i] <= pwr_v[i] != SCRB_PWR_DOWN;
			end
		end
	end

	a_addr_up: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
		(step_r && bus.addr_asc) |=> addr_r == 15'($past(addr_r) + 15'h0001))
		else $error("address did not increment");
	a_addr_down: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
		(step_r && !bus.addr_asc) |=> addr_r == 15'($past(addr_r) - 15'h0001))
		else $error("address did not decrement");
	a_tx_order: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
		(fall && !load_r && state_r == SCRB_DATA && rw_r && bus.lsb_first) |=> sdio_o_r == $past(tx_r[0]))
		else $error("lsb first read shifted wrong bit");
	a_soft_abort: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
		bus.soft_rst |=> (state_r == SCRB_HOLD && !wr_r && dp_rst_r) ##1 !dp_rst_r)
		else $error("soft reset did not stop the frame");
	a_pwr_down: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
		(pwr_v[0] == SCRB_PWR_DOWN) |=> (!clk_en_r[0] && hold_r[0] && !link_r[0]))
		else $error("power down outputs wrong");
	a_pwr_standby: assert property (@(posedge core_clk) disable iff (!nrst || !ce)
		(pwr_v[1] == SCRB_PWR_STANDBY) |=> (!clk_en_r[1] && !hold_r[1] && link_r[1]))
		else $error("standby outputs wrong");
endmodule
`default_nettype wire

// >>> sim/scrb_host.sv
`timescale 1ns/10ps
`default_nettype none
module scrb_host
	import scrb_pkg::*;
#(parameter int HALF = 10, parameter int BOOT = 100)
(
	input wire logic core_clk,
	input wire logic sdio_o,
	input wire logic sdio_oe,
	output logic sclk,
	output logic csb_n,
	output logic sdio_i
);
	logic lsb = 1'b0;
	logic drv = 1'b0;
	logic dv = 1'b0;
	logic lst = 1'b0;
	// no pull on the line: a released line toggles so a stale level cannot pass
	assign sdio_i = (sdio_oe === 1'b1) ? sdio_o : (drv ? dv : ~lst);
	always @(posedge core_clk) lst <= sdio_i;
	initial begin
		sclk = 1'b0;
		csb_n = 1'b1;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// 5 ms boot time, scaled down to keep the run short
	task automatic boot();
		tk(BOOT);
	endtask
	// callers address only the mapped set when writing
	task automatic xfer(input logic rd, input logic [14:0] a, input int n, input logic [7:0] wd,
		output logic [7:0] q [3]);
		logic [15:0] ins;
		ins = {rd, a};
		csb_n = 1'b0;
		for (int i = 0; i < 16 + 8 * n; i++) begin
			drv = !(rd && i > 15);
			dv = i < 16 ? ins[lsb ? i : 15 - i] : wd[lsb ? i % 8 : 7 - i % 8];
			tk(HALF);
			if (i > 15)
				q[i / 8 - 2][lsb ? i % 8 : 7 - i % 8] = sdio_i;
			sclk = 1'b1;
			tk(HALF);
			sclk = 1'b0;
		end
		drv = 1'b0;
		tk(HALF);
		csb_n = 1'b1;
		tk(4 * HALF);
	endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
	import scrb_pkg::*;
;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic ce = 1'b1;
	int p0 = 0;
	logic sclk, csb_n, sdio_i, sdio_o, sdio_oe, dp_rst;
	logic [1:0] clk_en, hold, link;
	int error_cnt = 0;
	int checks_done = 0;
	int pulses = 0;
	int cyc = 0;
	logic [7:0] q [3];
	scrb_top DUT(.core_clk(core_clk), .nrst(nrst), .ce(ce), .sclk(sclk), .csb_n(csb_n), .sdio_i(sdio_i),
		.sdio_o(sdio_o), .sdio_oe(sdio_oe), .dp_rst(dp_rst), .dp_clk_en(clk_en), .dp_hold_rst(hold),
		.link_en(link));
	scrb_host #(.HALF(10), .BOOT(100)) host(.core_clk(core_clk), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
		.sclk(sclk), .csb_n(csb_n), .sdio_i(sdio_i));
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	task automatic tally_and_finish();
		$display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// counts high cycles, so a stretched pulse shows as a wrong count
	always @(posedge core_clk) begin
		pulses <= pulses + int'(nrst && dp_rst);
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		host.xfer(1'b0, a, 1, d, q);
	endtask
	task automatic rd(input logic [14:0] a, input logic [7:0] e);
		host.xfer(1'b1, a, 1, 8'h00, q);
		check(q[0], e);
	endtask
	function automatic logic [7:0] pexp(input logic [1:0] ca, input logic [1:0] cb);
		pexp = {2'h0, ~cb[1], ~ca[1], cb == 2'h3, ca == 2'h3, cb != 2'h3, ca != 2'h3};
	endfunction
	task automatic pw(input logic [1:0] ca, input logic [1:0] cb);
		check({2'h0, clk_en, hold, link}, pexp(ca, cb));
	endtask
	task automatic do_reset();
		nrst = 1'b0;
		repeat (20) @(posedge core_clk);
		#1;
		nrst = 1'b1;
		host.tk(5);
	endtask
	initial begin
		do_reset();
		pw(2'h0, 2'h0);
		for (int i = 0; i < 5; i++)
			rd(15'(i), i == 3 ? SCRB_CLASS_CODE : 8'h00);
		rd(SCRB_ADDR_CHAN, 8'h03);
		wr(SCRB_ADDR_CLASS, 8'hff);
		rd(SCRB_ADDR_CLASS, SCRB_CLASS_CODE);
		$display("test defaults done");
		for (int k = 0; k < 4; k++) begin
			wr(SCRB_ADDR_PWR, 8'(3 - k));
			pw(2'(3 - k), 2'(3 - k));
			rd(SCRB_ADDR_PWR, 8'(3 - k));
		end
		wr(SCRB_ADDR_CHAN, 8'h01);
		wr(SCRB_ADDR_PWR, 8'h03);
		wr(SCRB_ADDR_CHAN, 8'h02);
		wr(SCRB_ADDR_PWR, 8'h02);
		pw(2'h3, 2'h2);
		rd(SCRB_ADDR_PWR, 8'h02);
		wr(SCRB_ADDR_CHAN, 8'h03);
		rd(SCRB_ADDR_PWR, 8'h03);
		$display("test power done");
		p0 = pulses;
		wr(SCRB_ADDR_CFG_B, 8'h02);
		check(8'(pulses - p0), 8'h01);
		rd(SCRB_ADDR_CFG_B, 8'h00);
		$display("test datapath reset done");
		wr(SCRB_ADDR_CFG_A, 8'h20);
		rd(SCRB_ADDR_CFG_A, 8'h24);
		host.xfer(1'b1, SCRB_ADDR_CFG_B, 3, 8'h00, q);
		check(q[0], 8'h00);
		check(q[1], 8'h03);
		check(q[2], SCRB_CLASS_CODE);
		wr(SCRB_ADDR_CFG_A, 8'h00);
		rd(SCRB_ADDR_CFG_A, 8'h00);
		host.xfer(1'b1, SCRB_ADDR_CLASS, 3, 8'h00, q);
		check(q[0], SCRB_CLASS_CODE);
		check(q[1], 8'h03);
		check(q[2], 8'h00);
		$display("test address step done");
		wr(SCRB_ADDR_CFG_A, 8'h02);
		host.lsb = 1'b1;
		rd(SCRB_ADDR_CFG_A, 8'h42);
		rd(SCRB_ADDR_CLASS, SCRB_CLASS_CODE);
		$display("test bit order done");
		p0 = pulses;
		wr(SCRB_ADDR_CFG_A, 8'h80);
		host.lsb = 1'b0;
		host.boot();
		check(8'(pulses - p0), 8'h01);
		pw(2'h0, 2'h0);
		rd(SCRB_ADDR_CFG_A, 8'h00);
		wr(SCRB_ADDR_PWR, 8'h02);
		p0 = pulses;
		wr(SCRB_ADDR_CFG_A, 8'h01);
		host.boot();
		check(8'(pulses - p0), 8'h01);
		pw(2'h0, 2'h0);
		rd(SCRB_ADDR_PWR, 8'h00);
		$display("test soft reset done");
		// a whole frame sent while frozen must leave no trace
		ce = 1'b0;
		wr(SCRB_ADDR_PWR, 8'h03);
		ce = 1'b1;
		host.tk(5);
		pw(2'h0, 2'h0);
		rd(SCRB_ADDR_PWR, 8'h00);
		$display("test clock enable done");
		wr(SCRB_ADDR_PWR, 8'h03);
		pw(2'h3, 2'h3);
		do_reset();
		pw(2'h0, 2'h0);
		rd(SCRB_ADDR_PWR, 8'h00);
		$display("test mid-run reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
